// File: src/adc_defines.svh
// register offsets, field positions, reset values, channel group code and result width for the converter control
`ifndef ADC_DEFINES_SVH
`define ADC_DEFINES_SVH

`define OFS_CTRL        8'h94
`define OFS_STATUS      8'hBC
`define OFS_CLKDIV      8'hFE
`define OFS_IVL_HI      8'hF7
`define OFS_IVL_MED     8'hF6
`define OFS_IVL_LO      8'hF5
`define OFS_INMUX       8'hFC
`define OFS_GAIN_AMP    8'hF9
`define OFS_RES_BASE    8'hA4
`define OFS_RES_LAST    8'hAB

`define CTRL_REF_SRC    7
`define CTRL_SINGLE_CH  6
`define CTRL_TRIGGER    5
`define CTRL_CONV_EN    4
`define CTRL_DONE_CLR   3
`define CTRL_IRQ_EN     2
`define CTRL_REPEAT     1
`define CTRL_REF_PWR    0
`define STAT_DONE       0
`define AMP_PWR         0
`define INMUX_ORDER     7

`define CTRL_RESET      8'h00
`define AMP_RESET       8'h00
`define INMUX_RESET     8'h00
`define CLKDIV_RESET    8'h00
`define IVL_RESET       24'h000000

`define CH_GROUP        3'h4
`define RESULT_BITS     12

`endif

// File: src/adc_pkg.sv
// types shared by the converter control modules
package adc_pkg;
    typedef enum logic [3:0] {
        SEQ_IDLE  = 4'b0001,
        SEQ_START = 4'b0010,
        SEQ_WAIT  = 4'b0100,
        SEQ_NEXT  = 4'b1000
    } seq_state_e;

    typedef logic [11:0] result_t;
    typedef logic [1:0]  slot_t;
endpackage

// File: src/result_if.sv
// carrier between the sequencer and the result memory
`timescale 1ns/1ps
interface result_if;
    logic                 wr_en;
    adc_pkg::slot_t       wr_slot;
    adc_pkg::result_t     wr_data;
    adc_pkg::slot_t       rd_slot;
    adc_pkg::result_t     rd_data;

    modport ctrl (output wr_en, output wr_slot, output wr_data, output rd_slot, input rd_data);
    modport mem  (input wr_en, input wr_slot, input wr_data, input rd_slot, output rd_data);
endinterface

// File: src/result_store.sv
// four 12-bit conversion result slots with registered read port
`timescale 1ns/1ps
module result_store (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic ce,
    result_if.mem     rif
);
    import adc_pkg::*;

    result_t slot_q [4];

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_slot
            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    slot_q[gi] <= 12'h000;
                end else if (ce && rif.wr_en && rif.wr_slot == slot_t'(gi)) begin
                    slot_q[gi] <= rif.wr_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rif.rd_data <= 12'h000;
        end else if (ce) begin
            rif.rd_data <= slot_q[rif.rd_slot];
        end
    end
endmodule // result_store

// File: src/ref_clk_div.sv
// converter reference clock: core clock divided by 2*divisor+2
`timescale 1ns/1ps
module ref_clk_div (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic [7:0] divisor,
    output logic            ref_clk
);
    logic [8:0] cnt_q;
    logic       ref_q;
    wire  [8:0] half_w = {1'b0, divisor};
    wire        flip_w = (cnt_q >= half_w);

    // toggling every divisor+1 cycles gives a full period of 2*divisor+2
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt_q <= 9'h000;
            ref_q <= 1'b0;
        end else if (ce) begin
            cnt_q <= flip_w ? 9'h000 : cnt_q + 9'h001;
            if (flip_w) begin
                ref_q <= ~ref_q;
            end
        end
    end

    assign ref_clk = ref_q;
endmodule // ref_clk_div

// File: src/adc_seq_ctrl.sv
// converter sequencing control: register bank, interval timer, pass sequencer
//
// How it works
// - repeated timed or single on-demand passes
// - single-channel bit picks one or four channels
// - four-channel pass fills four 12-bit results
// - single-channel result always lands in slot 0
// - results passed through as straight binary codes
// - interval is three bytes forming 24 bits
// - trigger bit starts one pass immediately
// - pass end sets status done flag
// - done flag holds until clear bit written
// - enabled done flag drives wake interrupt
// - reference clock is core clock over 2n+2
// - reference and amplifier start powered down
// - control bit 0 powers reference
// - amplifier register bit 0 powers amplifier
// - control bit 7 selects external reference pin
`timescale 1ns/1ps
`include "adc_defines.svh"
module adc_seq_ctrl (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic [7:0]       sfr_addr,
    input  wire logic             sfr_wr,
    input  wire logic [7:0]       sfr_wdata,
    input  wire logic             sfr_rd,
    output logic [7:0]            sfr_rdata,
    output logic                  conv_start,
    output logic [2:0]            conv_channel,
    input  wire logic             conv_busy_done,
    input  wire adc_pkg::result_t conv_data,
    output logic                  converter_ref_clk,
    output logic                  converter_power_on,
    output logic                  reference_power_on,
    output logic                  gain_amp_power_on,
    output logic [7:0]            gain_amp_setting,
    output logic                  reference_source_select,
    output logic                  reference_correction_order,
    output logic [3:0]            input_buffer_enable,
    output logic                  done_irq
);
    import adc_pkg::*;

    // bank registers
    logic [7:0]  ctrl_q;
    logic [7:0]  amp_q;
    logic [7:0]  inmux_q;
    logic [7:0]  clkdiv_q;
    logic [23:0] ivl_q;
    logic        done_q;
    logic [7:0]  rdata_q;
    logic        res_sel_q;
    logic        res_hi_q;

    // sequencer
    seq_state_e  state_q;
    seq_state_e  state_d;
    logic [1:0]  slot_q;
    logic [23:0] ivl_cnt_q;
    logic        pending_q;
    logic [2:0]  chan_hold_q;

    // conversion-end input from the analog core is asynchronous
    logic        done_s1_q;
    logic        done_s2_q;
    logic        done_s3_q;
    result_t     data_s1_q;
    result_t     data_s2_q;

    result_if rif ();

    result_store u_store (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .rif      (rif)
    );

    ref_clk_div u_div (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .divisor  (clkdiv_q),
        .ref_clk  (converter_ref_clk)
    );

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr == ofs;
    endfunction

    // address decode
    wire wr_ctrl   = sfr_wr && hit(sfr_addr, `OFS_CTRL);
    wire wr_amp    = sfr_wr && hit(sfr_addr, `OFS_GAIN_AMP);
    wire wr_inmux  = sfr_wr && hit(sfr_addr, `OFS_INMUX);
    wire wr_clkdiv = sfr_wr && hit(sfr_addr, `OFS_CLKDIV);
    wire wr_ivl_hi = sfr_wr && hit(sfr_addr, `OFS_IVL_HI);
    wire wr_ivl_md = sfr_wr && hit(sfr_addr, `OFS_IVL_MED);
    wire wr_ivl_lo = sfr_wr && hit(sfr_addr, `OFS_IVL_LO);
    wire res_hit   = (sfr_addr >= `OFS_RES_BASE) && (sfr_addr <= `OFS_RES_LAST);
    wire [7:0] res_ofs = sfr_addr - `OFS_RES_BASE;

    // trigger and done-clear are strobes: they act on the write and never store
    wire trigger_w  = wr_ctrl && sfr_wdata[`CTRL_TRIGGER];
    wire done_clr_w = wr_ctrl && sfr_wdata[`CTRL_DONE_CLR];

    wire single_ch_w = ctrl_q[`CTRL_SINGLE_CH];
    wire repeat_w    = ctrl_q[`CTRL_REPEAT];
    wire conv_en_w   = ctrl_q[`CTRL_CONV_EN];
    wire [2:0] muxsel_w = inmux_q[6:4];

    // interval timer: period equals the programmed value, a value of zero behaves as one
    wire [23:0] ivl_next_w = ivl_cnt_q + 24'h000001;
    wire        ivl_tick_w = repeat_w && conv_en_w && (ivl_next_w >= ivl_q);

    // stage three only remembers stage two for the rising-edge test
    wire done_rise_w = done_s2_q && !done_s3_q;
    wire last_slot_w = single_ch_w || (slot_q == 2'h3);
    // an enable dropped mid-pass abandons it, and no done flag follows
    wire pass_end_w  = (state_q == SEQ_NEXT) && last_slot_w && conv_en_w;
    // the enable written with the trigger counts, so one write can arm and fire
    wire en_now_w    = wr_ctrl ? sfr_wdata[`CTRL_CONV_EN] : conv_en_w;
    wire start_req_w = en_now_w && (pending_q || trigger_w || ivl_tick_w);

    // next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            SEQ_IDLE: begin
                if (start_req_w) begin
                    state_d = SEQ_START;
                end
            end
            SEQ_START: begin
                if (!conv_en_w) begin
                    state_d = SEQ_IDLE;
                end else begin
                    state_d = SEQ_WAIT;
                end
            end
            SEQ_WAIT: begin
                if (!conv_en_w) begin
                    state_d = SEQ_IDLE;
                end else if (done_rise_w) begin
                    state_d = SEQ_NEXT;
                end
            end
            SEQ_NEXT: begin
                if (last_slot_w || !conv_en_w) begin
                    state_d = SEQ_IDLE;
                end else begin
                    state_d = SEQ_START;
                end
            end
            default: begin
                state_d = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q <= SEQ_IDLE;
        end else if (ce) begin
            state_q <= state_d;
        end
    end

    // slot walks 0..3 during a four-channel pass
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            slot_q <= 2'h0;
        end else if (ce) begin
            if (state_q == SEQ_IDLE) begin
                slot_q <= 2'h0;
            end else if (state_q == SEQ_NEXT) begin
                slot_q <= slot_q + 2'h1;
            end
        end
    end

    // a request arriving while a pass runs is kept, not lost
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pending_q <= 1'b0;
        end else if (ce) begin
            if (state_q == SEQ_IDLE || !conv_en_w) begin
                pending_q <= 1'b0;
            end else if (trigger_w || ivl_tick_w) begin
                pending_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ivl_cnt_q <= 24'h000000;
        end else if (ce) begin
            ivl_cnt_q <= (ivl_tick_w || !repeat_w) ? 24'h000000 : ivl_next_w;
        end
    end

    // synchronisers: stage two carries done and data, stage three only feeds the rising-edge test
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            done_s1_q <= 1'b0;
            done_s2_q <= 1'b0;
            done_s3_q <= 1'b0;
            data_s1_q <= 12'h000;
            data_s2_q <= 12'h000;
        end else if (ce) begin
            done_s1_q <= conv_busy_done;
            done_s2_q <= done_s1_q;
            done_s3_q <= done_s2_q;
            data_s1_q <= conv_data;
            data_s2_q <= data_s1_q;
        end
    end

    // channel: manual picks the full mux code, group mode keeps the upper/lower bit
    wire [2:0] chan_now_w = single_ch_w ? muxsel_w : {muxsel_w[2], slot_q};

    // held from the start pulse on, so a mux write cannot move a running conversion
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            chan_hold_q <= 3'h0;
        end else if (ce && state_q == SEQ_START) begin
            chan_hold_q <= chan_now_w;
        end
    end

    assign conv_channel = (state_q == SEQ_START) ? chan_now_w : chan_hold_q;
    assign conv_start   = (state_q == SEQ_START);

    // result slot: always 0 for single channel
    assign rif.wr_en   = (state_q == SEQ_WAIT) && done_rise_w && conv_en_w;
    assign rif.wr_slot = single_ch_w ? 2'h0 : slot_q;
    assign rif.wr_data = data_s2_q;
    assign rif.rd_slot = res_ofs[2:1];

    // done flag: a pass ending in the clear cycle still sets it
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            done_q <= 1'b0;
        end else if (ce) begin
            if (pass_end_w) begin
                done_q <= 1'b1;
            end else if (done_clr_w) begin
                done_q <= 1'b0;
            end
        end
    end

    // combinational so it can wake a core whose own clock is stopped
    assign done_irq = done_q && ctrl_q[`CTRL_IRQ_EN];

    // writable registers; strobe bits never stored
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_q   <= `CTRL_RESET;
            amp_q    <= `AMP_RESET;
            inmux_q  <= `INMUX_RESET;
            clkdiv_q <= `CLKDIV_RESET;
        end else if (ce) begin
            if (wr_ctrl) begin
                ctrl_q <= sfr_wdata & 8'hD7;
            end
            if (wr_amp) begin
                amp_q <= sfr_wdata;
            end
            if (wr_inmux) begin
                inmux_q <= sfr_wdata;
            end
            if (wr_clkdiv) begin
                clkdiv_q <= sfr_wdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ivl_q <= `IVL_RESET;
        end else if (ce) begin
            if (wr_ivl_hi) begin
                ivl_q[23:16] <= sfr_wdata;
            end
            if (wr_ivl_md) begin
                ivl_q[15:8] <= sfr_wdata;
            end
            if (wr_ivl_lo) begin
                ivl_q[7:0] <= sfr_wdata;
            end
        end
    end

    // read side: bank registers captured here, result bytes come from the store's register
    logic [7:0] rd_mux;
    always_comb begin
        case (sfr_addr)
            `OFS_CTRL:     rd_mux = ctrl_q;
            `OFS_STATUS:   rd_mux = {7'h00, done_q};
            `OFS_CLKDIV:   rd_mux = clkdiv_q;
            `OFS_IVL_HI:   rd_mux = ivl_q[23:16];
            `OFS_IVL_MED:  rd_mux = ivl_q[15:8];
            `OFS_IVL_LO:   rd_mux = ivl_q[7:0];
            `OFS_INMUX:    rd_mux = inmux_q;
            `OFS_GAIN_AMP: rd_mux = amp_q;
            default:       rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata_q   <= 8'h00;
            res_sel_q <= 1'b0;
            res_hi_q  <= 1'b0;
        end else if (ce) begin
            rdata_q   <= sfr_rd ? rd_mux : 8'h00;
            res_sel_q <= sfr_rd && res_hit;
            res_hi_q  <= res_ofs[0];
        end
    end

    wire [7:0] res_byte_w = res_hi_q ? {4'h0, rif.rd_data[11:8]} : rif.rd_data[7:0];
    assign sfr_rdata = res_sel_q ? res_byte_w : rdata_q;

    assign converter_power_on         = conv_en_w;
    assign reference_power_on         = ctrl_q[`CTRL_REF_PWR];
    assign gain_amp_power_on          = amp_q[`AMP_PWR];
    assign gain_amp_setting           = amp_q;
    assign reference_source_select    = ctrl_q[`CTRL_REF_SRC];
    assign reference_correction_order = inmux_q[`INMUX_ORDER];
    assign input_buffer_enable        = inmux_q[3:0];
endmodule // adc_seq_ctrl

// File: bench/adc_seq_sva.sv
// assertion checker bound to the converter sequencing control ports
`timescale 1ns/1ps
`include "adc_defines.svh"
module adc_seq_sva (
    input wire logic             core_clk,
    input wire logic             rst_n,
    input wire logic             ce,
    input wire logic [7:0]       sfr_addr,
    input wire logic             sfr_wr,
    input wire logic [7:0]       sfr_wdata,
    input wire logic             sfr_rd,
    input wire logic [7:0]       sfr_rdata,
    input wire logic             conv_start,
    input wire logic [2:0]       conv_channel,
    input wire logic             reference_power_on,
    input wire logic             gain_amp_power_on,
    input wire logic [7:0]       gain_amp_setting,
    input wire logic             reference_source_select,
    input wire logic             reference_correction_order,
    input wire logic             done_irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire ctrl_wr = ce && sfr_wr && (sfr_addr == `OFS_CTRL);
    wire amp_wr  = ce && sfr_wr && (sfr_addr == `OFS_GAIN_AMP);
    wire mux_wr  = ce && sfr_wr && (sfr_addr == `OFS_INMUX);

    property p_rd_idle; ce && !sfr_rd ##1 ce |-> sfr_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
    property p_ctrl_bits;
        ctrl_wr |=> reference_power_on == $past(sfr_wdata[0])
                 && reference_source_select == $past(sfr_wdata[7]);
    endproperty
    a_ctrl_bits: assert property (p_ctrl_bits) else $error("control bits not applied");
    property p_amp; amp_wr |=> gain_amp_setting == $past(sfr_wdata) && gain_amp_power_on == $past(sfr_wdata[0]); endproperty
    a_amp: assert property (p_amp) else $error("amplifier register not applied");
    property p_order; mux_wr |=> reference_correction_order == $past(sfr_wdata[7]); endproperty
    a_order: assert property (p_order) else $error("correction order not applied");
    property p_irq_off; ctrl_wr && !sfr_wdata[2] |=> !done_irq; endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt seen while disabled");
    property p_irq_hold; done_irq && !ctrl_wr |=> done_irq; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("done dropped without clear");
    property p_start_pulse; conv_start |=> !conv_start; endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start wider than one cycle");
    property p_trig; ctrl_wr && sfr_wdata[5] && sfr_wdata[4] |-> ##[1:400] conv_start; endproperty
    a_trig: assert property (p_trig) else $error("trigger gave no conversion");
    property p_chan; conv_start |=> $stable(conv_channel) [*3]; endproperty
    a_chan: assert property (p_chan) else $error("channel moved during conversion");
    property p_reset;
        $rose(rst_n) |-> !reference_power_on && !gain_amp_power_on && !conv_start && !done_irq;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not idle after reset");
    c_start: cover property (conv_start);
endmodule // adc_seq_sva

bind adc_seq_ctrl adc_seq_sva u_sva (
    .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .conv_start(conv_start),
    .conv_channel(conv_channel), .reference_power_on(reference_power_on),
    .gain_amp_power_on(gain_amp_power_on), .gain_amp_setting(gain_amp_setting),
    .reference_source_select(reference_source_select),
    .reference_correction_order(reference_correction_order), .done_irq(done_irq)
);

// File: bench/conv_core_model.sv
// behavioural model of the analog conversion core
`timescale 1ns/1ps
module conv_core_model (
    input  wire logic        core_clk,
    input  wire logic        conv_start,
    input  wire logic [2:0]  conv_channel,
    input  wire logic [7:0]  lat,
    output logic             conv_busy_done,
    output adc_pkg::result_t conv_data
);
    import adc_pkg::*;
    logic [7:0] cnt_q = 8'h00;
    logic [2:0] hold_q = 3'h0;
    logic       busy_q = 1'b0;
    result_t    res_q = 12'h000;
    initial conv_busy_done = 1'b0;
    initial conv_data = 12'hC33;
    // data toggles through the countdown and once more as done falls, so nothing can lean on a stale code
    always @(posedge core_clk) begin
        if (conv_start) begin
            busy_q         <= 1'b1;
            cnt_q          <= lat;
            conv_busy_done <= 1'b0;
            res_q          <= {1'b1, conv_channel, 8'h5A};
        end else if (busy_q) begin
            if (cnt_q == 8'h00) begin
                busy_q         <= 1'b0;
                conv_busy_done <= 1'b1;
                hold_q         <= 3'h6;
            end else begin
                cnt_q     <= cnt_q - 8'h01;
                conv_data <= (cnt_q == 8'h01) ? res_q : ~conv_data;
            end
        end else if (hold_q != 3'h0) begin
            hold_q <= hold_q - 3'h1;
            if (hold_q == 3'h1) begin
                conv_busy_done <= 1'b0;
                conv_data      <= ~conv_data;
            end
        end
    end
endmodule // conv_core_model

// File: bench/tb_adc_seq_ctrl.sv
// self-checking bench for the converter sequencing control
`timescale 1ns/1ps
`include "adc_defines.svh"
module tb_adc_seq_ctrl;
    import adc_pkg::*;
    logic       core_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, lat = 8'h14, sfr_rdata, amp_set;
    logic       conv_start, conv_busy_done, ref_clk, cpwr, ref_pwr, amp_pwr, src_sel, corr;
    logic       done_irq;
    logic [2:0] conv_channel;
    logic [3:0] buf_en;
    result_t    conv_data;
    int         err_count = 0, check_count = 0, n;
    localparam logic [7:0] ADR [11] = '{`OFS_CTRL, `OFS_STATUS, `OFS_GAIN_AMP, `OFS_INMUX,
        `OFS_CLKDIV, `OFS_IVL_LO, `OFS_IVL_MED, `OFS_IVL_HI, `OFS_RES_BASE, `OFS_RES_LAST, 8'h10};
    localparam logic [7:0] WA [7] = '{`OFS_GAIN_AMP, `OFS_INMUX, `OFS_IVL_HI, `OFS_IVL_MED,
        `OFS_IVL_LO, `OFS_CTRL, 8'h10};
    localparam logic [7:0] WD [7] = '{8'hA5, 8'h8F, 8'h5A, 8'hC3, 8'h3C, 8'h8D, 8'hFF};
    localparam logic [7:0] WE [7] = '{8'hA5, 8'h8F, 8'h5A, 8'hC3, 8'h3C, 8'h85, 8'h00};

    always #25 core_clk = ~core_clk;

    adc_seq_ctrl dut (
        .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .conv_start(conv_start),
        .conv_channel(conv_channel), .conv_busy_done(conv_busy_done), .conv_data(conv_data),
        .converter_ref_clk(ref_clk), .converter_power_on(cpwr), .reference_power_on(ref_pwr),
        .gain_amp_power_on(amp_pwr), .gain_amp_setting(amp_set),
        .reference_source_select(src_sel), .reference_correction_order(corr),
        .input_buffer_enable(buf_en), .done_irq(done_irq)
    );
    conv_core_model model (
        .core_clk(core_clk), .conv_start(conv_start), .conv_channel(conv_channel), .lat(lat),
        .conv_busy_done(conv_busy_done), .conv_data(conv_data)
    );

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(negedge core_clk);
        sfr_wr = 1'b0;
    endtask
    // read data is valid for one cycle only, so it is taken at the very next falling edge
    task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] e);
        @(negedge core_clk);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        @(negedge core_clk);
        sfr_rd = 1'b0;
        chk(what, {16'h0, e}, {16'h0, sfr_rdata});
    endtask
    task automatic wait_for(ref logic s, output int c);
        c = 0;
        while (s !== 1'b1 && c < 2000) begin
            @(negedge core_clk);
            c++;
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        $display("Error watchdog expected finish seen hang");
        report_and_stop;
    end

    initial begin
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        chk("powered down", 24'h0, {21'h0, ref_pwr, amp_pwr, cpwr});
        foreach (ADR[i]) rdchk("reset value", ADR[i], 8'h00);
        foreach (WA[i]) begin
            wr(WA[i], WD[i]);
            rdchk("readback", WA[i], WE[i]);
        end
        chk("control pins", 24'hFF, {16'h0, ref_pwr, src_sel, amp_pwr, corr, buf_en});
        chk("amp setting", 24'hA5, {16'h0, amp_set});
        wr(`OFS_CLKDIV, 8'h02);
        n = 0;
        repeat (24) begin
            @(negedge core_clk);
            n += int'(ref_clk);
        end
        chk("ref clock high share", 24'd12, 24'(n));
        wr(`OFS_GAIN_AMP, 8'h01);
        wr(`OFS_INMUX, 8'hB0);
        wr(`OFS_CLKDIV, 8'h27);
        wr(`OFS_CTRL, 8'h75);
        wait_for(done_irq, n);
        chk("done irq", 24'h1, {23'h0, done_irq});
        rdchk("slot0 lo", `OFS_RES_BASE, 8'h5A);
        rdchk("slot0 hi", `OFS_RES_BASE + 8'h01, 8'h0B);
        rdchk("slot1 lo", `OFS_RES_BASE + 8'h02, 8'h00);
        rdchk("status", `OFS_STATUS, 8'h01);
        repeat (20) @(negedge core_clk);
        rdchk("status held", `OFS_STATUS, 8'h01);
        wr(`OFS_CTRL, 8'h1D);
        rdchk("status cleared", `OFS_STATUS, 8'h00);
        chk("irq cleared", 24'h0, {23'h0, done_irq});
        lat = 8'h02;
        wr(`OFS_INMUX, 8'h80);
        wr(`OFS_CTRL, 8'h35);
        wait_for(done_irq, n);
        for (int s = 0; s < 4; s++) begin
            rdchk("slot lo", `OFS_RES_BASE + 8'(2 * s), 8'h5A);
            rdchk("slot hi", `OFS_RES_BASE + 8'(2 * s + 1), 8'h08 | 8'(s));
        end
        wr(`OFS_CTRL, 8'h1D);
        wr(`OFS_IVL_HI, 8'h00);
        wr(`OFS_IVL_MED, 8'h01);
        wr(`OFS_IVL_LO, 8'h40);
        wr(`OFS_INMUX, 8'hA0);
        wr(`OFS_CTRL, 8'h53);
        wait_for(conv_start, n);
        @(negedge core_clk);
        wait_for(conv_start, n);
        chk("interval", 24'd320, 24'(n + 1));
        rdchk("repeat slot0 hi", `OFS_RES_BASE + 8'h01, 8'h0A);
        wr(`OFS_CTRL, 8'h01);
        wr(`OFS_CTRL, 8'h09);
        rdchk("status idle", `OFS_STATUS, 8'h00);
        report_and_stop;
    end
endmodule // tb_adc_seq_ctrl
